// ==== core/mst_alu.sv ====
// Combinational result, skip and flag logic for one instruction.
// Assumes operands are stable for the whole execute cycle.
module mst_alu (
   input wire mst_pkg::mst_op_e op,
   input wire logic [7:0] work,
   input wire logic [7:0] mem,
   input wire logic [7:0] imm,
   input wire logic [7:0] tab,
   input wire logic [2:0] bsel,
   output logic [7:0] res,
   output logic wr_mem,
   output logic wr_work,
   output logic skip,
   output logic upd_z,
   output logic upd_sub,
   output logic c,
   output logic half_borrow,
   output logic signed_range
);
   import mst_pkg::*;

   logic [7:0] sub_b;
   logic [8:0] d9;
   logic [4:0] h5;
   logic [7:0] bmask;

   always_comb begin
      sub_b = (op == OP_SUB_IMM) ? imm : mem;
      // Borrow-free carries: set means the result did not go negative
      d9 = {1'h0, work} + {1'h0, ~sub_b} + 9'h001;
      h5 = {1'h0, work[3:0]} + {1'h0, ~sub_b[3:0]} + 5'h01;
      c = d9[8];
      half_borrow = h5[4];
      signed_range = (work[7] ^ sub_b[7]) & (d9[7] ^ work[7]);
      bmask = 8'h01 << bsel;
      res = mem;
      wr_mem = 1'h0;
      wr_work = 1'h0;
      skip = 1'h0;
      upd_z = 1'h0;
      upd_sub = 1'h0;
      case (op)
         OP_SET_ALL: begin
            res = ALL_ONES;
            wr_mem = 1'h1;
         end
         OP_SET_BIT: begin
            res = mem | bmask;
            wr_mem = 1'h1;
         end
         OP_INC_SKIP: begin
            res = mem + 8'h01;
            wr_mem = 1'h1;
            skip = (res == 8'h00);
         end
         OP_INC_W_SKIP: begin
            res = mem + 8'h01;
            wr_work = 1'h1;
            skip = (res == 8'h00);
         end
         OP_DEC_W_SKIP: begin
            res = mem - 8'h01;
            wr_work = 1'h1;
            skip = (res == 8'h00);
         end
         OP_BIT_NZ_SKIP: skip = (mem & bmask) != 8'h00;
         OP_BIT_Z_SKIP: skip = (mem & bmask) == 8'h00;
         OP_MEM_Z_SKIP: begin
            wr_mem = 1'h1;
            skip = (mem == 8'h00);
         end
         OP_MEM_Z_COPY: begin
            wr_work = 1'h1;
            skip = (mem == 8'h00);
         end
         OP_SUB, OP_SUB_IMM: begin
            res = d9[7:0];
            wr_work = 1'h1;
            upd_sub = 1'h1;
         end
         OP_SUB_MEM: begin
            res = d9[7:0];
            wr_mem = 1'h1;
            upd_sub = 1'h1;
         end
         OP_SWAP: begin
            res = {mem[3:0], mem[7:4]};
            wr_mem = 1'h1;
         end
         OP_SWAP_W: begin
            res = {mem[3:0], mem[7:4]};
            wr_work = 1'h1;
         end
         OP_TAB_RD, OP_TAB_RDL: begin
            res = tab;
            wr_mem = 1'h1;
         end
         OP_XOR, OP_XOR_IMM: begin
            res = work ^ ((op == OP_XOR) ? mem : imm);
            wr_work = 1'h1;
            upd_z = 1'h1;
         end
         OP_XOR_MEM: begin
            res = work ^ mem;
            wr_mem = 1'h1;
            upd_z = 1'h1;
         end
         default: res = mem;
      endcase
   end
endmodule

// ==== core/mst_dmem.sv ====
// Byte-wide single-port data memory with a registered read port.
// Assumes one access per cycle; the caller arbitrates the port.
module mst_dmem #(
   parameter int AW = 7,
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata_ff
);
   logic [W-1:0] mem_q [2**AW];

   // No reset on the array: contents are undefined until written
   always_ff @(posedge clk) begin
      if (ce && en && we) begin
         mem_q[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && en && !we) begin
         rdata_ff <= mem_q[addr];
      end
   end
endmodule

// ==== core/mst_exec.sv ====
// Execution unit for the skip, set, subtract, swap, table-read and xor group.
// Assumes instructions arrive from fetch logic on the same clock, one at a
// time while op_ready is high, and that program memory answers one cycle
// after prog_rd.
//
// Contract
// - Fill-all writes FFH to the addressed byte, flags unchanged.
// - Bit set forces one selected bit to one, others kept, no flags.
// - Increment memory, store back, skip next when stored sum is zero.
// - Memory plus one into work register, memory kept, skip on zero.
// - Memory minus one into work register, memory kept, skip on zero.
// - A taken skip adds one dummy cycle, two instruction cycles total.
// - Skip next when the selected bit is one; no flag change.
// - Skip next when the selected bit is zero; no flag change.
// - Read byte, write same value back, skip when zero, no flags.
// - Copy byte to work register, skip when zero, no flags.
// - Work minus memory into work register; update ov, z, ac, c.
// - Subtraction carry is zero when negative, one when positive or zero.
// - Work minus memory written to memory; update the four flags.
// - Work minus literal kept in work register; update the four flags.
// - Swap byte nibbles and write back in place; no flags.
// - Swapped byte into work register; memory and flags unchanged.
// - Table read at pointer; low byte to memory, high to latch.
// - Last-page table read uses only low pointer on the final page.
// - Work xor memory into work register; only zero flag updated.
// - Work xor memory written to memory; only zero flag updated.
// - Work xor literal into work register; only zero flag updated.
//
// Implementation choices: the address map and the strobed register port.
module mst_exec #(
   parameter int DM_AW = 7,
   parameter bit HAS_PTR_HIGH = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic op_valid,
   input wire mst_pkg::mst_op_e op_code,
   input wire logic [DM_AW-1:0] op_addr,
   input wire logic [2:0] op_bit,
   input wire logic [mst_pkg::DW-1:0] op_imm,
   output logic op_ready,
   output logic op_done,
   output logic skip_taken,
   output logic dummy_cycle,
   output logic prog_rd,
   output logic [mst_pkg::PAW-1:0] prog_addr,
   input wire logic [mst_pkg::PW-1:0] prog_data,
   input wire logic [mst_pkg::BAW-1:0] bus_addr,
   input wire logic [mst_pkg::DW-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [mst_pkg::DW-1:0] bus_rdata
);
   import mst_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_DUMMY} mst_state_e;

   mst_state_e st_ff;
   mst_state_e nxt_st;
   mst_op_e op_ff;
   logic [DM_AW-1:0] addr_ff;
   logic [2:0] bit_ff;
   logic [7:0] imm_ff;
   logic [7:0] work_ff;
   logic [3:0] flags_ff;
   logic [7:0] ptr_low_ff;
   logic [7:0] ptr_high_ff;
   logic [7:0] high_latch_ff;
   logic [DM_AW-1:0] maddr_ff;
   logic [7:0] mdata_ff;
   logic mvalid_ff;
   logic ready_ff;
   logic done_ff;
   logic skip_ff;
   logic dummy_ff;
   logic prog_rd_ff;
   logic [PAW-1:0] prog_addr_ff;
   logic [7:0] rdata_ff;

   logic idle;
   logic exec;
   logic accept;
   logic bus_wr_ok;
   logic dm_en;
   logic dm_we;
   logic [DM_AW-1:0] dm_addr;
   logic [7:0] dm_wd;
   logic [7:0] dm_q;
   logic [7:0] alu_res;
   logic alu_wr_mem;
   logic alu_wr_work;
   logic alu_skip;
   logic alu_upd_z;
   logic alu_upd_sub;
   logic alu_c;
   logic alu_half_borrow;
   logic alu_signed_range;
   logic is_tab;
   logic [7:0] sub_b_w;

   assign idle = (st_ff == ST_IDLE);
   assign exec = (st_ff == ST_EXEC);
   assign accept = ce && idle && op_valid;
   // Software may only write core registers between instructions
   assign bus_wr_ok = ce && bus_wr && idle;
   assign is_tab = (op_ff == OP_TAB_RD) || (op_ff == OP_TAB_RDL);
   assign sub_b_w = (op_ff == OP_SUB_IMM) ? imm_ff : dm_q;

   assign op_ready = ready_ff;
   assign op_done = done_ff;
   assign skip_taken = skip_ff;
   assign dummy_cycle = dummy_ff;
   assign prog_rd = prog_rd_ff;
   assign prog_addr = prog_addr_ff;
   assign bus_rdata = rdata_ff;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: if (op_valid) nxt_st = ST_FETCH;
         ST_FETCH: nxt_st = ST_EXEC;
         ST_EXEC: nxt_st = alu_skip ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
         ready_ff <= 1'h1;
         done_ff <= 1'h0;
         skip_ff <= 1'h0;
         dummy_ff <= 1'h0;
      end else if (ce) begin
         st_ff <= nxt_st;
         ready_ff <= (nxt_st == ST_IDLE);
         done_ff <= (exec && !alu_skip) || (st_ff == ST_DUMMY);
         skip_ff <= exec && alu_skip;
         dummy_ff <= (nxt_st == ST_DUMMY);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_ff <= OP_SET_ALL;
         addr_ff <= '0;
         bit_ff <= 3'h0;
         imm_ff <= RST_BYTE;
      end else if (accept) begin
         op_ff <= op_code;
         addr_ff <= op_addr;
         bit_ff <= op_bit;
         imm_ff <= op_imm;
      end
   end

   // Program word read is issued during the operand fetch cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_rd_ff <= 1'h0;
         prog_addr_ff <= RST_PADDR;
      end else if (ce) begin
         prog_rd_ff <= accept && (op_code == OP_TAB_RD || op_code == OP_TAB_RDL);
         if (accept && op_code == OP_TAB_RDL) begin
            prog_addr_ff <= {LAST_PAGE, ptr_low_ff};
         end else if (accept && op_code == OP_TAB_RD) begin
            prog_addr_ff <= {HAS_PTR_HIGH ? ptr_high_ff : NO_HIGH_PTR, ptr_low_ff};
         end
      end
   end

   // Memory port: bus window when idle, operand read, then result write
   always_comb begin
      dm_en = 1'h0;
      dm_we = 1'h0;
      dm_addr = maddr_ff;
      dm_wd = bus_wdata;
      case (st_ff)
         ST_IDLE: begin
            dm_en = 1'h1;
            dm_we = bus_wr && (bus_addr == A_MDATA);
         end
         ST_FETCH: begin
            dm_en = 1'h1;
            dm_addr = addr_ff;
         end
         ST_EXEC: begin
            dm_en = alu_wr_mem;
            dm_we = alu_wr_mem;
            dm_addr = addr_ff;
            dm_wd = alu_res;
         end
         default: dm_en = 1'h0;
      endcase
   end

   mst_dmem #(
      .AW(DM_AW),
      .W(DW)
   ) u_dmem (
      .clk(clk),
      .ce(ce),
      .en(dm_en),
      .we(dm_we),
      .addr(dm_addr),
      .wdata(dm_wd),
      .rdata_ff(dm_q)
   );

   mst_alu u_alu (
      .op(op_ff),
      .work(work_ff),
      .mem(dm_q),
      .imm(imm_ff),
      .tab(prog_data[7:0]),
      .bsel(bit_ff),
      .res(alu_res),
      .wr_mem(alu_wr_mem),
      .wr_work(alu_wr_work),
      .skip(alu_skip),
      .upd_z(alu_upd_z),
      .upd_sub(alu_upd_sub),
      .c(alu_c),
      .half_borrow(alu_half_borrow),
      .signed_range(alu_signed_range)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_ff <= RST_BYTE;
      end else if (ce && exec && alu_wr_work) begin
         work_ff <= alu_res;
      end else if (bus_wr_ok && bus_addr == A_WORK) begin
         work_ff <= bus_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= RST_FLAGS;
      end else if (ce && exec && alu_upd_sub) begin
         flags_ff[F_C] <= alu_c;
         flags_ff[F_HALF_BORROW] <= alu_half_borrow;
         flags_ff[F_SIGNED_RANGE] <= alu_signed_range;
         flags_ff[F_Z] <= (alu_res == 8'h00);
      end else if (ce && exec && alu_upd_z) begin
         flags_ff[F_Z] <= (alu_res == 8'h00);
      end else if (bus_wr_ok && bus_addr == A_FLAGS) begin
         flags_ff <= bus_wdata[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_latch_ff <= RST_BYTE;
      end else if (ce && exec && is_tab) begin
         high_latch_ff <= prog_data[15:8];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_low_ff <= RST_BYTE;
         ptr_high_ff <= RST_BYTE;
         maddr_ff <= '0;
      end else if (bus_wr_ok) begin
         if (bus_addr == A_PTR_LOW) ptr_low_ff <= bus_wdata;
         if (bus_addr == A_PTR_HIGH && HAS_PTR_HIGH) ptr_high_ff <= bus_wdata;
         if (bus_addr == A_MADDR) maddr_ff <= bus_wdata[DM_AW-1:0];
      end
   end

   // Background read keeps a readable copy of the byte at the window address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mvalid_ff <= 1'h0;
         mdata_ff <= RST_BYTE;
      end else if (ce) begin
         mvalid_ff <= idle && !dm_we;
         if (mvalid_ff) mdata_ff <= dm_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= RST_BYTE;
      end else if (ce) begin
         rdata_ff <= 8'h00;
         if (bus_rd) begin
            case (bus_addr)
               A_WORK: rdata_ff <= work_ff;
               A_FLAGS: rdata_ff <= {4'h0, flags_ff};
               A_PTR_LOW: rdata_ff <= ptr_low_ff;
               A_PTR_HIGH: rdata_ff <= ptr_high_ff;
               A_HIGH_LATCH: rdata_ff <= high_latch_ff;
               A_STATE: rdata_ff <= {4'h0, ready_ff, dummy_ff, st_ff};
               A_MADDR: rdata_ff <= 8'(maddr_ff);
               A_MDATA: rdata_ff <= mdata_ff;
               default: rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_fill_ones: assert property (exec && op_ff == OP_SET_ALL |->
      dm_we && dm_wd == 8'hFF && !alu_upd_z && !alu_upd_sub)
      else $error("fill-all did not write all ones");

   a_bit_set: assert property (exec && op_ff == OP_SET_BIT |->
      dm_we && dm_wd == (dm_q | (8'h01 << bit_ff)))
      else $error("bit set wrong");

   a_inc_store: assert property (exec && op_ff == OP_INC_SKIP |->
      dm_wd == dm_q + 8'h01 && alu_skip == (dm_q == 8'hFF))
      else $error("increment-skip wrong");

   a_inc_work: assert property (exec && ce && op_ff == OP_INC_W_SKIP |=>
      work_ff == $past(dm_q) + 8'h01)
      else $error("increment to work wrong");

   a_dec_work: assert property (exec && ce && op_ff == OP_DEC_W_SKIP |=>
      work_ff == $past(dm_q) - 8'h01 && skip_taken == (work_ff == 8'h00))
      else $error("decrement to work wrong");

   a_skip_dummy: assert property (exec && ce && alu_skip |=>
      (dummy_cycle && !op_ready && !op_done) and (ce |=> op_done))
      else $error("taken skip not two cycles");

   a_bit_skip: assert property (exec && op_ff == OP_BIT_Z_SKIP |->
      alu_skip == !dm_q[bit_ff] && !alu_upd_z)
      else $error("bit-zero skip wrong");

   a_sub_carry: assert property (exec && ce && alu_upd_sub |=>
      flags_ff[F_C] == ($past(work_ff) >= $past(sub_b_w)))
      else $error("subtract carry wrong");

   a_sub_work: assert property (exec && ce && op_ff == OP_SUB |=>
      work_ff == $past(work_ff) - $past(dm_q))
      else $error("subtract result wrong");

   a_swap_back: assert property (exec && op_ff == OP_SWAP |->
      dm_we && dm_wd == {dm_q[3:0], dm_q[7:4]})
      else $error("nibble swap wrong");

   a_tab_latch: assert property (exec && ce && is_tab |=>
      high_latch_ff == $past(prog_data[15:8]))
      else $error("table high latch wrong");

   a_last_page: assert property (accept && op_code == OP_TAB_RDL |=>
      prog_rd && prog_addr == {8'hFF, $past(ptr_low_ff)})
      else $error("last-page address wrong");

   a_xor_zero: assert property (exec && ce && op_ff == OP_XOR |=>
      work_ff == ($past(work_ff) ^ $past(dm_q)) && flags_ff[F_Z] == (work_ff == 8'h00)
      && flags_ff[F_C] == $past(flags_ff[F_C]))
      else $error("xor to work wrong");

   c_skip_taken: cover property (skip_taken && dummy_cycle ##1 op_done);
   c_table_read: cover property (exec && ce && op_ff == OP_TAB_RD);
   c_sub_borrow: cover property (exec && ce && alu_upd_sub && !alu_c);
endmodule

// ==== core/mst_pkg.sv ====
// Shared constants and types for the skip/subtract/xor/table execution block.
// Assumes an 8-bit data path, 16-bit program words and a byte-wide register port.
package mst_pkg;

   localparam int DW = 8;
   localparam int PW = 16;
   localparam int PAW = 16;
   localparam int BAW = 8;

   // Register port offsets
   localparam logic [7:0] A_WORK = 8'h00;
   localparam logic [7:0] A_FLAGS = 8'h01;
   localparam logic [7:0] A_PTR_LOW = 8'h02;
   localparam logic [7:0] A_PTR_HIGH = 8'h03;
   localparam logic [7:0] A_HIGH_LATCH = 8'h04;
   localparam logic [7:0] A_STATE = 8'h05;
   localparam logic [7:0] A_MADDR = 8'h06;
   localparam logic [7:0] A_MDATA = 8'h07;

   // Flag field positions inside the flag register
   localparam int F_C = 0;
   localparam int F_HALF_BORROW = 1;
   localparam int F_Z = 2;
   localparam int F_SIGNED_RANGE = 3;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [15:0] RST_PADDR = 16'h0000;

   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] LAST_PAGE = 8'hFF;
   localparam logic [7:0] NO_HIGH_PTR = 8'h00;

   typedef enum logic [4:0] {
      OP_SET_ALL, OP_SET_BIT, OP_INC_SKIP, OP_INC_W_SKIP, OP_DEC_W_SKIP,
      OP_BIT_NZ_SKIP, OP_BIT_Z_SKIP, OP_MEM_Z_SKIP, OP_MEM_Z_COPY,
      OP_SUB, OP_SUB_MEM, OP_SUB_IMM, OP_SWAP, OP_SWAP_W,
      OP_TAB_RD, OP_TAB_RDL, OP_XOR, OP_XOR_MEM, OP_XOR_IMM
   } mst_op_e;

endpackage

// ==== verification/mcu_skip_sub_xor_table_ops_tb.sv ====
// Self-checking bench for the skip, set, subtract, swap, table-read and xor unit.
// Assumes mst_exec with a 7-bit memory address and a high table pointer present;
// the bench plays fetch logic, program memory and register master itself.
module mcu_skip_sub_xor_table_ops_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mst_pkg::*;

   logic clk, rst_n, ce, op_valid, bus_wr, bus_rd;
   mst_op_e op_code;
   logic [6:0] op_addr;
   logic [2:0] op_bit;
   logic [7:0] op_imm, bus_addr, bus_wdata, bus_rdata;
   logic op_ready, op_done, skip_taken, dummy_cycle, prog_rd;
   logic [15:0] prog_addr, prog_data;
   int error_cnt = 0;
   int num_checks = 0;

   mst_exec #(.DM_AW(7), .HAS_PTR_HIGH(1'b1)) dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .op_valid(op_valid), .op_code(op_code),
      .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .op_ready(op_ready),
      .op_done(op_done), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
      .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata)
   );

   always #2.5 clk = ~clk;

   function automatic logic [15:0] prog_fn(input logic [15:0] pa);
      return {pa[7:0] ^ 8'h3C, pa[15:8] ^ 8'hC3};
   endfunction

   // Program memory answers one cycle after the request; between reads the word
   // keeps changing so a late sample cannot pass by luck
   always @(posedge clk) begin
      prog_data <= prog_rd ? prog_fn(prog_addr) : ~prog_data;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   // The memory window copy needs two idle cycles after the address is set
   task automatic mem_rd(input logic [6:0] a, output logic [7:0] d);
      bus_write(A_MADDR, {1'b0, a});
      repeat (3) @(posedge clk);
      bus_read(A_MDATA, d);
   endtask

   task automatic run_op(input mst_op_e op, input logic [6:0] a, input logic [2:0] b,
      input logic [7:0] imm, output logic sk, output int n);
      logic dm;
      sk = 1'b0;
      dm = 1'b0;
      n = 0;
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      op_addr <= a;
      op_bit <= b;
      op_imm <= imm;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      check("prog_rd", prog_rd, op inside {OP_TAB_RD, OP_TAB_RDL});
      check("busy", op_ready, 1'b0);
      do begin
         @(posedge clk);
         #1;
         n++;
         sk = sk | (skip_taken === 1'b1);
         dm = dm | (dummy_cycle === 1'b1);
      end while (op_done !== 1'b1 && n < 20);
      check("dummy", dm, sk);
   endtask

   task automatic predict(input mst_op_e op, input logic [7:0] m, input logic [7:0] w,
      input logic [7:0] imm, input logic [2:0] b, input logic [15:0] pw,
      inout logic [7:0] nm, inout logic [7:0] nw, inout logic [7:0] nh,
      inout logic [3:0] nf, output logic sk);
      logic [8:0] d;
      logic [7:0] s;
      s = (op == OP_SUB_IMM) ? imm : m;
      d = {1'b0, w} - {1'b0, s};
      case (op)
         OP_SET_ALL: nm = ALL_ONES;
         OP_SET_BIT: nm[b] = 1'b1;
         OP_INC_SKIP: nm = m + 8'h01;
         OP_INC_W_SKIP: nw = m + 8'h01;
         OP_DEC_W_SKIP: nw = m - 8'h01;
         OP_MEM_Z_COPY: nw = m;
         OP_SUB, OP_SUB_IMM: nw = d[7:0];
         OP_SUB_MEM: nm = d[7:0];
         OP_SWAP: nm = {m[3:0], m[7:4]};
         OP_SWAP_W: nw = {m[3:0], m[7:4]};
         OP_TAB_RD, OP_TAB_RDL: nm = pw[7:0];
         OP_XOR: nw = w ^ m;
         OP_XOR_MEM: nm = w ^ m;
         OP_XOR_IMM: nw = w ^ imm;
         default: ;
      endcase
      if (op inside {OP_TAB_RD, OP_TAB_RDL})
         nh = pw[15:8];
      case (op)
         OP_INC_SKIP, OP_INC_W_SKIP: sk = (m == 8'hFF);
         OP_DEC_W_SKIP: sk = (m == 8'h01);
         OP_BIT_NZ_SKIP: sk = m[b];
         OP_BIT_Z_SKIP: sk = !m[b];
         OP_MEM_Z_SKIP, OP_MEM_Z_COPY: sk = (m == 8'h00);
         default: sk = 1'b0;
      endcase
      if (op inside {OP_SUB, OP_SUB_MEM, OP_SUB_IMM})
         nf = {(w[7] != s[7]) && (d[7] != w[7]), d[7:0] == 8'h00, w[3:0] >= s[3:0], !d[8]};
      if (op inside {OP_XOR, OP_XOR_MEM, OP_XOR_IMM})
         nf[F_Z] = (((op == OP_XOR_IMM) ? (w ^ imm) : (w ^ m)) == 8'h00);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end

   initial begin
      mst_op_e op;
      logic [6:0] a;
      logic [2:0] b;
      logic [7:0] m, w, imm, tp, th, nm, nw, nh, rd, hl;
      logic [7:0] cm [4];
      logic [7:0] cw [4];
      logic [3:0] f, nf;
      logic [15:0] pa;
      logic sk, esk;
      int n;
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      op_valid = 1'b0;
      op_code = OP_SET_ALL;
      op_addr = 7'h00;
      op_bit = 3'h0;
      op_imm = 8'h00;
      prog_data = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      // Zero results, wrap of increment and decrement, signed overflow
      cm = '{8'hFF, 8'h00, 8'h01, 8'h80};
      cw = '{8'h00, 8'h00, 8'h01, 8'h7F};
      hl = RST_BYTE;
      void'($urandom(32'hD4671016));
      repeat (4) @(posedge clk);
      check("reset prog_addr", prog_addr, RST_PADDR);
      rst_n <= 1'b1;
      #1;
      check("reset ready", op_ready, 1'b1);
      bus_read(A_FLAGS, rd);
      check("reset flags", rd[3:0], RST_FLAGS);
      bus_read(A_WORK, rd);
      check("reset work", rd, RST_BYTE);
      for (int i = 0; i <= int'(OP_XOR_IMM); i++) begin
         for (int k = 0; k < 6; k++) begin
            op = mst_op_e'(i);
            a = 7'($urandom);
            b = 3'($urandom);
            f = 4'($urandom);
            tp = 8'($urandom);
            th = 8'($urandom);
            m = (k < 4) ? cm[k] : 8'($urandom);
            w = (k < 4) ? cw[k] : 8'($urandom);
            imm = (k < 4) ? m : 8'($urandom);
            bus_write(A_MADDR, {1'b0, a});
            bus_write(A_MDATA, m);
            bus_write(A_WORK, w);
            bus_write(A_FLAGS, {4'h0, f});
            bus_write(A_PTR_LOW, tp);
            bus_write(A_PTR_HIGH, th);
            run_op(op, a, b, imm, sk, n);
            pa = {(op == OP_TAB_RDL) ? LAST_PAGE : th, tp};
            nm = m;
            nw = w;
            nh = hl;
            nf = f;
            predict(op, m, w, imm, b, prog_fn(pa), nm, nw, nh, nf, esk);
            hl = nh;
            check("skip", sk, esk);
            check("cycles", 16'(n), 16'(2 + esk));
            bus_read(A_WORK, rd);
            check("work", rd, nw);
            bus_read(A_FLAGS, rd);
            check("flags", rd[3:0], nf);
            bus_read(A_HIGH_LATCH, rd);
            check("table high", rd, nh);
            mem_rd(a, rd);
            check("memory", rd, nm);
            if (op inside {OP_TAB_RD, OP_TAB_RDL})
               check("prog_addr", prog_addr, pa);
         end
      end
      // Read-only latch ignores writes, unmapped space reads as zero
      bus_write(A_HIGH_LATCH, ~hl);
      bus_read(A_HIGH_LATCH, rd);
      check("table high ro", rd, hl);
      // Clock enable low must freeze the register port as well
      bus_read(A_WORK, w);
      ce <= 1'b0;
      bus_write(A_WORK, ~w);
      ce <= 1'b1;
      bus_read(A_WORK, rd);
      check("frozen work", rd, w);
      bus_read(8'h20, rd);
      check("unmapped", rd, 8'h00);
      bus_read(A_STATE, rd);
      check("idle state", rd, 8'h08);
      give_verdict();
   end
endmodule
